// *** src/lcd_serial_pkg.sv ***
`default_nettype none
package lcd_serial_pkg;
	// command codes seen on the link
	localparam logic [7:0] CMD_READ_ID = 8'h04;
	localparam logic [7:0] CMD_COL_SET = 8'h2A;
	localparam logic [7:0] CMD_ROW_SET = 8'h2B;
	localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;
	localparam logic [7:0] CMD_PIXEL_FORMAT = 8'h3A;
	// pixel format parameter, low three bits
	localparam logic [2:0] FMT_12 = 3'h3;
	localparam logic [2:0] FMT_16 = 3'h5;
	localparam logic [2:0] FMT_18 = 3'h6;
	localparam logic [2:0] FMT_RESET = 3'h6;
	// frame memory geometry
	localparam int MEM_COLS = 132;
	localparam int MEM_ROWS = 162;
	localparam int MEM_DEPTH = MEM_COLS * MEM_ROWS;
	localparam int ADDR_W = 15;
	localparam int PIX_W = 18;
	localparam logic [7:0] END_COL_RESET = 8'h83;
	localparam logic [7:0] END_ROW_RESET = 8'hA1;
	// byte framing and identity read
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int ID_W = 24;
	localparam logic [4:0] ID_LAST = 5'h17;
	localparam logic [4:0] ID_COUNT = 5'h18;
	// arbitrary identity value, names no real part
	localparam logic [23:0] IDENTITY_VALUE = 24'h5A_3C96;
	// host link clock timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCK_HALF_NS = 200;
	localparam logic [3:0] SCK_HALF_CYC = 4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// *** src/serial_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic sck;
	logic chip_select_n;
	logic data_command_select;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic sda;
	// shared data wire, pulled high when nobody drives
	assign sda = !host_sda_oe_n ? host_sda_out : (!dev_sda_oe_n ? dev_sda_out : 1'b1);
	modport host (
		output sck,
		output chip_select_n,
		output data_command_select,
		output host_sda_out,
		output host_sda_oe_n,
		input sda
	);
	modport device (
		input sck,
		input chip_select_n,
		input data_command_select,
		input sda,
		output dev_sda_out,
		output dev_sda_oe_n
	);
endinterface
`default_nettype wire

// *** src/lcd_serial_device.sv ***
// Contract
// R1: select low marks a command byte
// R2: select high routes byte to memory or parameter
// R3: bytes shift most significant bit first
// R4: chip select high holds port in reset
// R5: chip select falling starts a new transfer
// R6: commands accepted in any order
// R7: read command returns bytes on data line
// R8: host raises chip select after a read
// R9: sample on rising, drive on falling clock
// R10: host captures read bits on rising edge
// R11: host releases data line by last bit
// R12: identity read returns 24 bits
// R13: paused data or parameters resume after pause
// R14: paused command accepts parameters or new command
// R15: twelve, sixteen and eighteen bit pixels
// R16: continuous download wraps pointer to start
// R17: host stops write by command between frames
// R18: only complete pixels reach memory
// R19: format six means 6-6-6 msb first
// R20: memory of 132 by 162 18-bit pixels
// R21: panel reads never disturb host writes
// R22: column advances, wraps, then row advances
// R23: partial byte discarded when chip select rises
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_device (
	input wire logic clk,
	input wire logic rst,
	serial_link_if.device link,
	output logic cmd_strobe,
	output logic [7:0] cmd_byte,
	output logic param_strobe,
	output logic [7:0] param_byte,
	output logic pix_strobe,
	output logic [lcd_serial_pkg::PIX_W-1:0] pix_data,
	output logic [7:0] pix_col,
	output logic [7:0] pix_row,
	input wire logic [lcd_serial_pkg::ADDR_W-1:0] panel_addr,
	output logic [lcd_serial_pkg::PIX_W-1:0] panel_data
);
	import lcd_serial_pkg::*;

	// link side: all but the finished-byte hold is held in reset while chip select is high
	logic port_clear;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [6:0] rx_shift_reg, rx_shift_next;
	logic read_active_reg, read_active_next;
	logic [7:0] rx_byte;
	assign port_clear = rst | link.chip_select_n; // [R4] [R5] [R23]
	assign rx_byte = {rx_shift_reg, link.sda}; // [R3]

	// byte assembly; bits from the released line during a read are ignored
	always_comb begin
		bit_cnt_next = bit_cnt_reg;
		rx_shift_next = rx_shift_reg;
		read_active_next = read_active_reg;
		if (!read_active_reg) begin
			bit_cnt_next = bit_cnt_reg + 3'h1;
			rx_shift_next = rx_byte[6:0];
			if (bit_cnt_reg == LAST_BIT && !link.data_command_select && rx_byte == CMD_READ_ID) begin
				read_active_next = 1'b1; // [R7]
			end
		end
	end

	always_ff @(posedge link.sck or posedge port_clear) begin // [R9]
		if (port_clear) begin
			bit_cnt_reg <= 3'h0;
			rx_shift_reg <= 7'h00;
			read_active_reg <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			rx_shift_reg <= rx_shift_next;
			read_active_reg <= read_active_next;
		end
	end

	// finished byte is held steady and announced by a toggle
	logic [7:0] hold_byte_reg, hold_byte_next;
	logic hold_dc_reg, hold_dc_next;
	logic byte_tgl_reg, byte_tgl_next;
	always_comb begin
		hold_byte_next = hold_byte_reg;
		hold_dc_next = hold_dc_reg;
		byte_tgl_next = byte_tgl_reg;
		if (!read_active_reg && bit_cnt_reg == LAST_BIT) begin
			hold_byte_next = rx_byte;
			hold_dc_next = link.data_command_select;
			byte_tgl_next = ~byte_tgl_reg;
		end
	end

	// not cleared by chip select, so a pause cannot drop a finished byte
	always_ff @(posedge link.sck or posedge rst) begin
		if (rst) begin
			hold_byte_reg <= 8'h00;
			hold_dc_reg <= 1'b0;
			byte_tgl_reg <= 1'b0;
		end else begin
			hold_byte_reg <= hold_byte_next;
			hold_dc_reg <= hold_dc_next;
			byte_tgl_reg <= byte_tgl_next;
		end
	end

	// read-back shifter, changes on falling clock edges and is cleared while chip select is high
	logic [4:0] out_idx_reg, out_idx_next;
	logic sda_out_reg, sda_out_next;
	logic oe_n_reg, oe_n_next;
	always_comb begin
		out_idx_next = out_idx_reg;
		sda_out_next = sda_out_reg;
		oe_n_next = 1'b1;
		if (read_active_reg && out_idx_reg < ID_COUNT) begin
			sda_out_next = IDENTITY_VALUE[ID_LAST - out_idx_reg]; // [R12] [R3]
			out_idx_next = out_idx_reg + 5'h01;
			oe_n_next = 1'b0;
		end
	end

	always_ff @(negedge link.sck or posedge port_clear) begin // [R9]
		if (port_clear) begin
			out_idx_reg <= 5'h00;
			sda_out_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			out_idx_reg <= out_idx_next;
			sda_out_reg <= sda_out_next;
			oe_n_reg <= oe_n_next;
		end
	end
	assign link.dev_sda_out = sda_out_reg;
	assign link.dev_sda_oe_n = oe_n_reg;

	// system side: toggle crossing
	logic tgl_s1_reg, tgl_s2_reg, tgl_seen_reg;
	logic new_byte;
	assign new_byte = tgl_s2_reg ^ tgl_seen_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_seen_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= byte_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_seen_reg <= tgl_s2_reg;
		end
	end

	// command decode, pixel assembly and address counters
	logic [7:0] cmd_reg, cmd_next;
	logic [1:0] param_idx_reg, param_idx_next;
	logic [2:0] fmt_reg, fmt_next;
	logic wr_mode_reg, wr_mode_next;
	logic [1:0] phase_reg, phase_next;
	logic [15:0] acc_reg, acc_next;
	logic [7:0] col_reg, col_next, row_reg, row_next;
	logic [7:0] xs_reg, xs_next, xe_reg, xe_next, ys_reg, ys_next, ye_reg, ye_next;
	logic cmd_strobe_next, param_strobe_next, pix_strobe_next;
	logic [7:0] cmd_byte_next, param_byte_next, pix_col_next, pix_row_next;
	logic [PIX_W-1:0] pix_data_next;

	always_comb begin
		logic [7:0] b;
		logic pix_ok;
		logic [PIX_W-1:0] pix;
		b = hold_byte_reg;
		pix_ok = 1'b0;
		pix = '0;
		{cmd_next, param_idx_next, fmt_next, wr_mode_next} = {cmd_reg, param_idx_reg, fmt_reg, wr_mode_reg};
		{phase_next, acc_next, col_next, row_next} = {phase_reg, acc_reg, col_reg, row_reg};
		{xs_next, xe_next, ys_next, ye_next} = {xs_reg, xe_reg, ys_reg, ye_reg};
		{cmd_strobe_next, param_strobe_next, pix_strobe_next} = 3'h0;
		cmd_byte_next = cmd_byte;
		param_byte_next = param_byte;
		pix_data_next = pix_data;
		pix_col_next = pix_col;
		pix_row_next = pix_row;
		if (new_byte && !hold_dc_reg) begin
			// any command at any time; a pending partial pixel is dropped
			cmd_next = b; // [R1] [R6] [R14]
			cmd_strobe_next = 1'b1;
			cmd_byte_next = b;
			param_idx_next = 2'h0;
			phase_next = 2'h0; // [R18]
			wr_mode_next = (b == CMD_MEM_WRITE); // [R17]
			if (b == CMD_MEM_WRITE) begin
				col_next = xs_reg;
				row_next = ys_reg;
			end
		end else if (new_byte && wr_mode_reg) begin
			phase_next = phase_reg + 2'h1; // [R2] [R13]
			unique case (fmt_reg) // [R15]
				FMT_12: begin
					if (phase_reg == 2'h0) begin
						acc_next = {8'h00, b};
					end else if (phase_reg == 2'h1) begin
						pix_ok = 1'b1;
						pix = {acc_reg[7:4], acc_reg[7:6], acc_reg[3:0], acc_reg[3:2], b[7:4], b[7:6]};
						acc_next = {12'h000, b[3:0]};
					end else begin
						pix_ok = 1'b1;
						pix = {acc_reg[3:0], acc_reg[3:2], b[7:4], b[7:6], b[3:0], b[3:2]};
						phase_next = 2'h0;
					end
				end
				FMT_16: begin
					if (phase_reg == 2'h0) begin
						acc_next = {8'h00, b};
					end else begin
						pix_ok = 1'b1;
						pix = {acc_reg[7:3], acc_reg[7], acc_reg[2:0], b[7:5], b[4:0], b[4]};
						phase_next = 2'h0;
					end
				end
				default: begin
					// eighteen-bit, each colour in the top six bits of its byte
					if (phase_reg == 2'h0) begin
						acc_next = {b, 8'h00};
					end else if (phase_reg == 2'h1) begin
						acc_next = {acc_reg[15:8], b};
					end else begin
						pix_ok = 1'b1;
						pix = {acc_reg[15:10], acc_reg[7:2], b[7:2]}; // [R19]
						phase_next = 2'h0;
					end
				end
			endcase
		end else if (new_byte) begin
			param_strobe_next = 1'b1; // [R2]
			param_byte_next = b;
			param_idx_next = param_idx_reg + 2'h1; // [R13]
			if (cmd_reg == CMD_PIXEL_FORMAT && param_idx_reg == 2'h0) begin
				if (b[2:0] == FMT_12 || b[2:0] == FMT_16 || b[2:0] == FMT_18) begin
					fmt_next = b[2:0]; // [R19]
				end
			end
			if (cmd_reg == CMD_COL_SET && param_idx_reg == 2'h1) begin
				xs_next = b;
			end
			if (cmd_reg == CMD_COL_SET && param_idx_reg == 2'h3) begin
				xe_next = b;
			end
			if (cmd_reg == CMD_ROW_SET && param_idx_reg == 2'h1) begin
				ys_next = b;
			end
			if (cmd_reg == CMD_ROW_SET && param_idx_reg == 2'h3) begin
				ye_next = b;
			end
		end
		if (pix_ok) begin
			pix_strobe_next = 1'b1; // [R18]
			pix_data_next = pix;
			pix_col_next = col_reg;
			pix_row_next = row_reg;
			if (col_reg >= xe_reg) begin
				col_next = xs_reg; // [R22]
				row_next = (row_reg >= ye_reg) ? ys_reg : row_reg + 8'h01; // [R16]
			end else begin
				col_next = col_reg + 8'h01; // [R22]
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cmd_reg, param_idx_reg, fmt_reg, wr_mode_reg} <= {8'h00, 2'h0, FMT_RESET, 1'b0};
			{phase_reg, acc_reg, col_reg, row_reg} <= {2'h0, 16'h0000, 8'h00, 8'h00};
			{xs_reg, xe_reg, ys_reg, ye_reg} <= {8'h00, END_COL_RESET, 8'h00, END_ROW_RESET};
			{cmd_strobe, param_strobe, pix_strobe} <= 3'h0;
			{cmd_byte, param_byte, pix_col, pix_row} <= 32'h0000_0000;
			pix_data <= '0;
		end else begin
			{cmd_reg, param_idx_reg, fmt_reg, wr_mode_reg} <= {cmd_next, param_idx_next, fmt_next, wr_mode_next};
			{phase_reg, acc_reg, col_reg, row_reg} <= {phase_next, acc_next, col_next, row_next};
			{xs_reg, xe_reg, ys_reg, ye_reg} <= {xs_next, xe_next, ys_next, ye_next};
			{cmd_strobe, param_strobe, pix_strobe} <= {cmd_strobe_next, param_strobe_next, pix_strobe_next};
			{cmd_byte, param_byte, pix_col, pix_row} <= {cmd_byte_next, param_byte_next, pix_col_next, pix_row_next};
			pix_data <= pix_data_next;
		end
	end

	// frame memory: separate write and panel read ports, so refresh never stalls writes
	logic [PIX_W-1:0] frame_mem [0:MEM_DEPTH-1]; // [R20]
	logic [ADDR_W-1:0] wr_index;
	assign wr_index = ADDR_W'(int'(pix_row) * MEM_COLS + int'(pix_col));
	always_ff @(posedge clk) begin
		if (pix_strobe && int'(pix_col) < MEM_COLS && int'(pix_row) < MEM_ROWS) begin
			frame_mem[wr_index] <= pix_data; // [R21]
		end
	end

	// same-address collision reads the old word for one cycle, no corruption
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			panel_data <= '0;
		end else if (int'(panel_addr) < MEM_DEPTH) begin
			panel_data <= frame_mem[panel_addr]; // [R21]
		end
	end
endmodule
`default_nettype wire

// *** src/lcd_serial_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_host (
	input wire logic clk,
	input wire logic rst,
	serial_link_if.host link,
	input wire logic cmd_valid,
	input wire logic cmd_dc,
	input wire logic [7:0] cmd_byte,
	input wire logic [1:0] cmd_read_bytes,
	input wire logic cmd_release,
	output logic cmd_ready,
	output logic rd_valid,
	output logic [7:0] rd_byte
);
	import lcd_serial_pkg::*;

	typedef enum logic [1:0] {st_idle, st_low, st_high, st_gap} host_state_t;

	// returning data passes two flip-flops before use
	logic sda_s1_reg, sda_s2_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
		end else begin
			sda_s1_reg <= link.sda;
			sda_s2_reg <= sda_s1_reg;
		end
	end

	host_state_t state_reg, state_next;
	logic [3:0] div_reg, div_next;
	logic [2:0] bit_reg, bit_next;
	logic [1:0] rd_left_reg, rd_left_next;
	logic reading_reg, reading_next, release_reg, release_next;
	logic [7:0] shift_reg, shift_next;
	logic sck_reg, sck_next, cs_n_reg, cs_n_next, dc_reg, dc_next;
	logic sda_out_reg, sda_out_next, oe_n_reg, oe_n_next;
	logic rd_valid_next;
	logic [7:0] rd_byte_next;
	logic half_done;
	assign half_done = (div_reg == SCK_HALF_CYC - 4'h1);

	// half-period divider drives the link clock; data moves while clock is low
	always_comb begin
		state_next = state_reg;
		div_next = div_reg + 4'h1;
		{bit_next, rd_left_next, reading_next, release_next} = {bit_reg, rd_left_reg, reading_reg, release_reg};
		{shift_next, sck_next, cs_n_next, dc_next} = {shift_reg, sck_reg, cs_n_reg, dc_reg};
		{sda_out_next, oe_n_next} = {sda_out_reg, oe_n_reg};
		rd_valid_next = 1'b0;
		rd_byte_next = rd_byte;
		unique case (state_reg)
			st_idle: begin
				div_next = 4'h0;
				sck_next = 1'b0;
				if (cmd_valid) begin
					cs_n_next = 1'b0;
					dc_next = cmd_dc;
					sda_out_next = cmd_byte[7]; // [R3]
					shift_next = {cmd_byte[6:0], 1'b0};
					oe_n_next = 1'b0;
					rd_left_next = cmd_read_bytes;
					release_next = cmd_release | (cmd_read_bytes != 2'h0); // [R8]
					reading_next = 1'b0;
					bit_next = 3'h0;
					state_next = st_low;
				end
			end
			st_low: begin
				if (half_done) begin
					div_next = 4'h0;
					sck_next = 1'b1;
					state_next = st_high;
					if (reading_reg) begin
						shift_next = {shift_reg[6:0], sda_s2_reg}; // [R10]
						if (bit_reg == LAST_BIT) begin
							rd_valid_next = 1'b1;
							rd_byte_next = {shift_reg[6:0], sda_s2_reg};
						end
					end
				end
			end
			st_high: begin
				if (half_done) begin
					div_next = 4'h0;
					sck_next = 1'b0;
					state_next = st_low;
					if (bit_reg != LAST_BIT) begin
						bit_next = bit_reg + 3'h1;
						if (!reading_reg) begin
							sda_out_next = shift_reg[7];
							shift_next = {shift_reg[6:0], 1'b0};
						end
					end else begin
						bit_next = 3'h0;
						if (!reading_reg && rd_left_reg != 2'h0) begin
							reading_next = 1'b1;
							oe_n_next = 1'b1; // [R11]
						end else if (reading_reg && rd_left_reg > 2'h1) begin
							rd_left_next = rd_left_reg - 2'h1;
						end else begin
							oe_n_next = 1'b1;
							state_next = release_reg ? st_gap : st_idle;
							cs_n_next = release_reg ? 1'b1 : cs_n_reg; // [R8]
						end
					end
				end
			end
			st_gap: begin
				// chip select stays high one half period before the next byte
				if (half_done) begin
					state_next = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= st_idle;
			div_reg <= 4'h0;
			{bit_reg, rd_left_reg, reading_reg, release_reg} <= {3'h0, 2'h0, 1'b0, 1'b0};
			{shift_reg, sck_reg, cs_n_reg, dc_reg} <= {8'h00, 1'b0, 1'b1, 1'b0};
			{sda_out_reg, oe_n_reg} <= {1'b0, 1'b1};
			rd_valid <= 1'b0;
			rd_byte <= 8'h00;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			{bit_reg, rd_left_reg, reading_reg, release_reg} <= {bit_next, rd_left_next, reading_next, release_next};
			{shift_reg, sck_reg, cs_n_reg, dc_reg} <= {shift_next, sck_next, cs_n_next, dc_next};
			{sda_out_reg, oe_n_reg} <= {sda_out_next, oe_n_next};
			rd_valid <= rd_valid_next;
			rd_byte <= rd_byte_next;
		end
	end

	assign cmd_ready = (state_reg == st_idle);
	assign link.sck = sck_reg;
	assign link.chip_select_n = cs_n_reg;
	assign link.data_command_select = dc_reg;
	assign link.host_sda_out = sda_out_reg;
	assign link.host_sda_oe_n = oe_n_reg;
endmodule
`default_nettype wire

// *** test/lcd_serial_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic chip_select_n,
	input wire logic data_command_select,
	input wire logic host_sda_out,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe_n,
	input wire logic sda
);
	import lcd_serial_pkg::*;
	logic sck_reg, sck_next;
	logic [4:0] rise_cnt_reg, rise_cnt_next;
	// count link clock rises while the device drives, to size the read-back
	always_comb begin
		sck_next = sck;
		rise_cnt_next = dev_sda_oe_n ? 5'h0 : rise_cnt_reg + 5'(sck && !sck_reg);
	end
	// sck is sampled as data here; its period is several clk cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_reg <= 1'b0;
			rise_cnt_reg <= 5'h0;
		end else begin
			sck_reg <= sck_next;
			rise_cnt_reg <= rise_cnt_next;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_idle_sck_low: assert property (chip_select_n |-> !sck)
		else $error("link clock moves while deselected");
	chk_dc_steady: assert property ((!chip_select_n && sck) |-> $stable(data_command_select))
		else $error("select line changed inside a byte");
	chk_host_bit_steady: assert property ((!host_sda_oe_n && sck) |-> $stable(host_sda_out))
		else $error("host data changed while clock high");
	chk_dev_shift_fall: assert property ((!dev_sda_oe_n && $changed(dev_sda_out)) |-> $fell(sck))
		else $error("device data changed off the falling edge");
	chk_no_contention: assert property (!(!host_sda_oe_n && !dev_sda_oe_n))
		else $error("both ends drive the data wire");
	chk_quiet_unsel: assert property (chip_select_n |-> dev_sda_oe_n)
		else $error("device drives while deselected");
	chk_turnaround: assert property ($fell(dev_sda_oe_n) |-> (host_sda_oe_n && !sck && !chip_select_n))
		else $error("device took the wire at a wrong moment");
	chk_id_length: assert property ($rose(dev_sda_oe_n) |-> rise_cnt_reg == ID_COUNT)
		else $error("read-back length is not 24 bits");
	chk_sck_high_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("link clock high phase has wrong length");
	chk_wire_pullup: assert property ((host_sda_oe_n && dev_sda_oe_n) |-> sda)
		else $error("released data wire not high");
	cov_read: cover property ($fell(dev_sda_oe_n));
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lcd_serial_pkg::*;
	localparam logic [33:0] NONE = 34'h3_FFFF_FFFF;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0, cmd_dc = 1'b0, cmd_release = 1'b0, wr_mode = 1'b0;
	logic [7:0] host_byte = 8'h00, rd_byte, dev_cmd_byte, param_byte, pix_col, pix_row, wire_sh;
	logic [1:0] cmd_read_bytes = 2'h0;
	logic cmd_ready, rd_valid, cmd_strobe, param_strobe, pix_strobe;
	logic [PIX_W-1:0] pix_data, panel_data;
	logic [ADDR_W-1:0] panel_addr = 15'h0000;
	logic [7:0] exp_cmd[$], exp_par[$], exp_rd[$], exp_wire[$];
	logic [33:0] exp_pix[$];
	logic [9:0] win[10] = '{10'h22A, 10'h100, 10'h302, 10'h100, 10'h303,
		10'h02B, 10'h100, 10'h105, 10'h100, 10'h306};
	int n_fail = 0;
	int num_checks = 0;
	int wire_cnt = 0;
	serial_link_if link();
	lcd_serial_host u_lcd_serial_host (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
		.cmd_dc(cmd_dc), .cmd_byte(host_byte), .cmd_read_bytes(cmd_read_bytes),
		.cmd_release(cmd_release), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_byte(rd_byte));
	lcd_serial_device u_lcd_serial_device (.clk(clk), .rst(rst), .link(link),
		.cmd_strobe(cmd_strobe), .cmd_byte(dev_cmd_byte), .param_strobe(param_strobe),
		.param_byte(param_byte), .pix_strobe(pix_strobe), .pix_data(pix_data), .pix_col(pix_col),
		.pix_row(pix_row), .panel_addr(panel_addr), .panel_data(panel_data));
	lcd_serial_asserts u_lcd_serial_asserts (.clk(clk), .rst(rst), .sck(link.sck),
		.chip_select_n(link.chip_select_n), .data_command_select(link.data_command_select),
		.host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n),
		.dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));
	// 20 mhz system clock
	always #25 clk = ~clk;
	task chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one byte through the host port; expectations are queued when it is taken
	task send(input logic dc, input logic [7:0] b, input logic [1:0] rd, input logic rel);
		int n;
		@(negedge clk);
		for (n = 0; n < 1000 && cmd_ready !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_dc <= dc;
		host_byte <= b;
		cmd_read_bytes <= rd;
		cmd_release <= rel;
		@(posedge clk);
		cmd_valid <= 1'b0;
		exp_wire.push_back(b);
		if (!dc) begin
			exp_cmd.push_back(b);
			wr_mode = (b == CMD_MEM_WRITE);
		end else if (!wr_mode) exp_par.push_back(b);
	endtask
	task px(input logic [5:0] r, g, b, input logic [7:0] c, rw);
		exp_pix.push_back({r, g, b, c, rw});
	endtask
	// one 18-bit pixel, colour in the top six bits of each byte
	task p18(input logic [5:0] r, g, b, input logic [7:0] c, rw, input logic rel);
		px(r, g, b, c, rw);
		send(1'b1, {r, 2'b00}, 2'h0, rel);
		send(1'b1, {g, 2'b00}, 2'h0, 1'b0);
		send(1'b1, {b, 2'b00}, 2'h0, 1'b0);
	endtask
	// panel word comes one clk after its address
	task peek(input logic [7:0] c, rw, input logic [PIX_W-1:0] exp);
		@(posedge clk);
		panel_addr <= ADDR_W'(rw * MEM_COLS + c);
		@(posedge clk);
		@(posedge clk);
		@(negedge clk);
		chk(panel_data, exp);
	endtask
	task final_report;
		if (exp_cmd.size() + exp_par.size() + exp_pix.size() + exp_rd.size() + exp_wire.size() != 0) begin
			n_fail++;
			$display("[FAIL] %0t expected transfers never seen", $time);
		end
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// strobes are one-cycle registers, so each is looked at on exactly one edge
	always @(posedge clk) begin
		if (cmd_strobe) chk(dev_cmd_byte, exp_cmd.size() ? exp_cmd.pop_front() : NONE);
		if (param_strobe) chk(param_byte, exp_par.size() ? exp_par.pop_front() : NONE);
		if (pix_strobe) chk({pix_data, pix_col, pix_row}, exp_pix.size() ? exp_pix.pop_front() : NONE);
		if (rd_valid) chk(rd_byte, exp_rd.size() ? exp_rd.pop_front() : NONE);
	end
	// rebuild host bytes from the wire at each rising link clock
	always @(posedge link.sck) begin
		if (!link.chip_select_n && !link.host_sda_oe_n) begin
			wire_sh = {wire_sh[6:0], link.sda};
			wire_cnt++;
			if (wire_cnt == 8) begin
				wire_cnt = 0;
				chk(wire_sh, exp_wire.size() ? exp_wire.pop_front() : NONE);
			end
		end
	end
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		$display("[FAIL] %0t run did not finish", $time);
		final_report();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// window cols 2..3, rows 5..6 with pauses after the column command and three parameters
		foreach (win[i]) send(win[i][8], win[i][7:0], 2'h0, win[i][9]);
		send(1'b0, CMD_PIXEL_FORMAT, 2'h0, 1'b0);
		send(1'b1, {5'h00, FMT_12}, 2'h0, 1'b0);
		send(1'b0, CMD_MEM_WRITE, 2'h0, 1'b1);
		px(6'h2A, 6'h15, 6'h33, 8'h02, 8'h05);
		px(6'h0C, 6'h26, 6'h19, 8'h03, 8'h05);
		foreach (exp_wire[i]) ;
		send(1'b1, 8'hA5, 2'h0, 1'b0);
		send(1'b1, 8'hC3, 2'h0, 1'b0);
		send(1'b1, 8'h96, 2'h0, 1'b0);
		send(1'b0, CMD_PIXEL_FORMAT, 2'h0, 1'b0);
		send(1'b1, {5'h00, FMT_16}, 2'h0, 1'b0);
		send(1'b0, CMD_MEM_WRITE, 2'h0, 1'b0);
		px(6'h3F, 6'h00, 6'h3F, 8'h02, 8'h05);
		send(1'b1, 8'hF8, 2'h0, 1'b0);
		send(1'b1, 8'h1F, 2'h0, 1'b0);
		send(1'b1, 8'h55, 2'h0, 1'b0);
		send(1'b0, CMD_PIXEL_FORMAT, 2'h0, 1'b0);
		send(1'b1, {5'h00, FMT_18}, 2'h0, 1'b0);
		send(1'b0, CMD_MEM_WRITE, 2'h0, 1'b0);
		// five pixels into a four-pixel window wrap back to the start
		for (int i = 0; i < 5; i++) p18(6'(i), 6'(i + 8), 6'(40 - i), 8'(2 + i % 2), 8'(5 + (i / 2) % 2), i == 1);
		send(1'b1, 8'hFC, 2'h0, 1'b0);
		exp_rd.push_back(IDENTITY_VALUE[23:16]);
		exp_rd.push_back(IDENTITY_VALUE[15:8]);
		exp_rd.push_back(IDENTITY_VALUE[7:0]);
		send(1'b0, CMD_READ_ID, 2'h3, 1'b1);
		send(1'b0, CMD_PIXEL_FORMAT, 2'h0, 1'b1);
		send(1'b1, {5'h00, FMT_18}, 2'h0, 1'b1);
		peek(8'h03, 8'h05, {6'h01, 6'h09, 6'h27});
		peek(8'h02, 8'h05, {6'h04, 6'h0C, 6'h24});
		repeat (200) @(posedge clk);
		final_report();
	end
endmodule
`default_nettype wire
